// File: inc/agtz_pkg.sv
// Shared constants for the front-end gain, thermal and zero-cross control
package agtz_pkg;

  // ****************************************************
  // Register map (byte addresses)
  // ****************************************************
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_RX_GAIN   = 8'h04;
  localparam logic [7:0] ADDR_TX_LEVEL  = 8'h08;
  localparam logic [7:0] ADDR_ZC_DELAY  = 8'h0c;
  localparam logic [7:0] ADDR_STATUS    = 8'h10;
  localparam logic [7:0] ADDR_ZC_PERIOD = 8'h14;

  // ****************************************************
  // Field positions
  // ****************************************************
  localparam int CTRL_AGC_BIT    = 0;
  localparam int CTRL_ZC_DIG_BIT = 1;
  localparam int CTRL_OP_BIT     = 2;
  localparam int TX_APPLIED_LSB  = 8;
  localparam int STAT_ZONE_LSB   = 0;
  localparam int STAT_AMP_BIT    = 3;
  localparam int STAT_LOCK_BIT   = 4;
  localparam int STAT_SHUT_BIT   = 5;
  localparam int STAT_FOLD_BIT   = 6;

  // ****************************************************
  // Values after reset and code limits
  // ****************************************************
  localparam logic [3:0]        RX_GAIN_MIN   = 4'h0;
  localparam logic [3:0]        RX_GAIN_UNITY = 4'h3;
  localparam logic [3:0]        RX_GAIN_MAX   = 4'h8;
  localparam logic [4:0]        TX_LEVEL_MAX  = 5'h1f;
  localparam logic signed [5:0] ATTEN_OFFSET  = 6'sh1f;
  localparam logic [2:0]        ZONE_ONE      = 3'h1;
  localparam logic [2:0]        ZONE_TWO      = 3'h2;
  localparam logic [2:0]        ZONE_THREE    = 3'h3;
  localparam logic [2:0]        ZONE_FOUR     = 3'h4;

  // ****************************************************
  // Timing
  // ****************************************************
  localparam int CLK_MHZ        = 50;
  localparam int AGC_STEP_US    = 20;
  localparam int FOLD_STEP_US   = 10;
  localparam int ZC_LOCK_TOL_US = 100;
  localparam int AGC_STEP_CYC   = AGC_STEP_US * CLK_MHZ;
  localparam int FOLD_STEP_CYC  = FOLD_STEP_US * CLK_MHZ;
  localparam int ZC_LOCK_TOL_CYC = ZC_LOCK_TOL_US * CLK_MHZ;
  localparam int STEP_CNT_W     = 16;
  localparam int ZC_CNT_W       = 21;

endpackage

// File: rtl/agtz_sync.sv
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ns
`default_nettype none
module agtz_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } agtz_sync_type;

  agtz_sync_type st_ff;
  agtz_sync_type nxt_st;

  // ****************************************************
  // Stage one feeds stage two only
  // ****************************************************
  always_comb begin
    nxt_st        = st_ff;
    nxt_st.stage1 = async_in;
    nxt_st.stage2 = st_ff.stage1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  assign sync_out = st_ff.stage2;

endmodule
`default_nettype wire

// File: rtl/agtz_zc_track.sv
// Zero-cross period tracker with phase flywheel and delay compensation
`timescale 1ns/1ns
`default_nettype none
module agtz_zc_track
  import agtz_pkg::*;
#(
  parameter int CNT_W   = ZC_CNT_W,
  parameter int TOL_CYC = ZC_LOCK_TOL_CYC
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             clk_en,
  input  wire logic             enable,
  input  wire logic             zc_level,
  input  wire logic [15:0]      delay_cyc,
  output logic                  ref_pulse,
  output logic                  locked,
  output logic      [CNT_W-1:0] period
);

  generate
    if (CNT_W < 17 || TOL_CYC < 1) begin : g_bad
      $error("agtz_zc_track: counter too narrow or tolerance zero");
    end
  endgenerate

  typedef struct packed {
    logic             prev;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] period;
    logic [CNT_W-1:0] phase;
    logic             locked;
    logic             ref_pulse;
  } agtz_zc_type;

  localparam logic [CNT_W-1:0] TOL   = CNT_W'(TOL_CYC);
  localparam logic [CNT_W-1:0] ONE   = CNT_W'(1);

  agtz_zc_type st_ff;
  agtz_zc_type nxt_st;
  logic        rise;

  // ****************************************************
  // Edge capture, period measure, phase realignment
  // ****************************************************
  always_comb begin
    nxt_st    = st_ff;
    rise      = zc_level && !st_ff.prev;
    nxt_st.prev = zc_level;
    // Saturate so a dead mains input never wraps into a false lock
    if (st_ff.cnt != '1) begin
      nxt_st.cnt = st_ff.cnt + ONE;
    end
    if (!enable) begin
      nxt_st.locked = 1'b0;
      nxt_st.cnt    = '0;
      nxt_st.phase  = '0;
    end else if (rise) begin
      nxt_st.period = st_ff.cnt;
      nxt_st.cnt    = ONE;  // Edge cycle counts toward the next period
      nxt_st.phase  = '0;
      nxt_st.locked = (st_ff.cnt >= st_ff.period)
                      ? (st_ff.cnt - st_ff.period) <= TOL
                      : (st_ff.period - st_ff.cnt) <= TOL;
    end else if (st_ff.phase + ONE >= st_ff.period) begin
      // Flywheel keeps the reference running through a missed edge
      nxt_st.phase = '0;
    end else begin
      nxt_st.phase = st_ff.phase + ONE;
    end
    // Reference fires a programmed delay after the realigned phase
    nxt_st.ref_pulse = enable && st_ff.locked
                       && st_ff.phase == CNT_W'(delay_cyc);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  assign ref_pulse = st_ff.ref_pulse;
  assign locked    = st_ff.locked;
  assign period    = st_ff.period;

endmodule
`default_nettype wire

// File: rtl/agtz_afe_ctrl.sv
// Front-end control: receive gain loop, transmit level, thermal, zero cross
`timescale 1ns/1ns
`default_nettype none
module agtz_afe_ctrl
  import agtz_pkg::*;
#(
  parameter int AGC_CYC  = AGC_STEP_CYC,
  parameter int FOLD_CYC = FOLD_STEP_CYC
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                clk_en,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                adc_over_range,
  input  wire logic                adc_under_range,
  input  wire logic                current_sense_pin,
  input  wire logic                temp_threshold_one,
  input  wire logic                temp_threshold_two,
  input  wire logic                temp_threshold_three,
  input  wire logic                temp_threshold_four,
  input  wire logic                zero_cross_analog_input,
  input  wire logic                zero_cross_digital_input,
  output logic      [3:0]          rx_gain_code,
  output logic      [4:0]          tx_level,
  output logic signed [5:0]        tx_atten_db,
  output logic                     amp_enable,
  output logic      [2:0]          temp_zone,
  output logic                     zc_ref_pulse,
  output logic                     zc_locked,
  output logic                     protocol_core_clock
);

  generate
    if (AGC_CYC < 1 || AGC_CYC >= (1 << STEP_CNT_W) ||
        FOLD_CYC < 1 || FOLD_CYC >= (1 << STEP_CNT_W)) begin : g_bad
      $error("agtz_afe_ctrl: step period outside counter range");
    end
  endgenerate

  typedef struct packed {
    logic                  agc_en;
    logic                  zc_dig;
    logic                  op_mode;
    logic [3:0]            rx_gain;
    logic [4:0]            tx_set;
    logic [4:0]            tx_lvl;
    logic signed [5:0]     atten;
    logic [15:0]           zc_delay;
    logic                  amp_en;
    logic [2:0]            zone;
    logic [STEP_CNT_W-1:0] agc_cnt;
    logic [STEP_CNT_W-1:0] fold_cnt;
    logic                  fold_act;
    logic                  proto_clk;
    logic [31:0]           rdata;
  } agtz_state_type;

  agtz_state_type        st_ff;
  agtz_state_type        nxt_st;
  logic [8:0]            s_pins;
  logic                  s_over;
  logic                  s_under;
  logic                  s_cur;
  logic                  s_t1;
  logic                  s_t2;
  logic                  s_t3;
  logic                  s_t4;
  logic                  s_zca;
  logic                  s_zcd;
  logic                  zc_sel;
  logic                  agc_tick;
  logic                  fold_tick;
  logic                  wr_en;
  logic                  rd_setup;
  logic [ZC_CNT_W-1:0]   zc_period;

  // Decoded address check for the error answer; read data decodes the address in its own case
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == ADDR_CTRL)     || (a == ADDR_RX_GAIN) ||
              (a == ADDR_TX_LEVEL) || (a == ADDR_ZC_DELAY) ||
              (a == ADDR_STATUS)   || (a == ADDR_ZC_PERIOD);
  endfunction

  // ****************************************************
  // Pin synchronisers and zero-cross tracker
  // ****************************************************
  agtz_sync #(.W(9)) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .clk_en   (clk_en),
    .async_in ({zero_cross_digital_input, zero_cross_analog_input,
                temp_threshold_four, temp_threshold_three,
                temp_threshold_two, temp_threshold_one,
                current_sense_pin, adc_under_range, adc_over_range}),
    .sync_out (s_pins)
  );

  assign {s_zcd, s_zca, s_t4, s_t3, s_t2, s_t1, s_cur, s_under, s_over}
         = s_pins;

  // Source select; the digital wave must be a clean square wave
  assign zc_sel = st_ff.zc_dig ? s_zcd : s_zca;

  agtz_zc_track u_zc (
    .pclk      (pclk),
    .presetn   (presetn),
    .clk_en    (clk_en),
    .enable    (st_ff.op_mode),
    .zc_level  (zc_sel),
    .delay_cyc (st_ff.zc_delay),
    .ref_pulse (zc_ref_pulse),
    .locked    (zc_locked),
    .period    (zc_period)
  );

  // ****************************************************
  // Bus handshake: zero wait states, stalled by clock enable
  // ****************************************************
  assign pready   = clk_en;
  assign wr_en    = psel && penable && pwrite && clk_en;
  assign rd_setup = psel && !penable;
  assign pslverr  = psel && penable && !addr_ok(paddr);
  assign prdata   = st_ff.rdata;

  assign agc_tick  = (st_ff.agc_cnt == '0);
  assign fold_tick = (st_ff.fold_cnt == '0);

  // ****************************************************
  // Next-state logic
  // ****************************************************
  always_comb begin
    nxt_st = st_ff;
    // Step timers
    nxt_st.agc_cnt  = agc_tick ? STEP_CNT_W'(AGC_CYC - 1)
                               : st_ff.agc_cnt - 1'b1;
    nxt_st.fold_cnt = fold_tick ? STEP_CNT_W'(FOLD_CYC - 1)
                                : st_ff.fold_cnt - 1'b1;
    // Gain loop; overload takes priority so the converter never clips
    if (st_ff.agc_en && agc_tick) begin
      if (s_over && st_ff.rx_gain != RX_GAIN_MIN) begin
        nxt_st.rx_gain = st_ff.rx_gain - 1'b1;
      end else if (!s_over && s_under && st_ff.rx_gain != RX_GAIN_MAX) begin
        nxt_st.rx_gain = st_ff.rx_gain + 1'b1;
      end
    end
    // Foldback holds until software reloads the setpoint
    nxt_st.fold_act = s_cur;
    if (fold_tick && s_cur && st_ff.tx_lvl != '0) begin
      nxt_st.tx_lvl = st_ff.tx_lvl - 1'b1;
    end
    // Thermal shutdown with hysteresis
    if (s_t4) begin
      nxt_st.amp_en = 1'b0;
    end else if (!st_ff.amp_en && !s_t3) begin
      nxt_st.amp_en = 1'b1;
    end
    // Thermometer zones
    if (s_t3) begin
      nxt_st.zone = ZONE_FOUR;
    end else if (s_t2) begin
      nxt_st.zone = ZONE_THREE;
    end else if (s_t1) begin
      nxt_st.zone = ZONE_TWO;
    end else begin
      nxt_st.zone = ZONE_ONE;
    end
    // Protocol clock is the core clock halved
    nxt_st.proto_clk = !st_ff.proto_clk;
    // Host writes win over the loops in the same cycle
    if (wr_en) begin
      case (paddr)
        ADDR_CTRL: begin
          nxt_st.agc_en  = pwdata[CTRL_AGC_BIT];
          nxt_st.zc_dig  = pwdata[CTRL_ZC_DIG_BIT];
          nxt_st.op_mode = pwdata[CTRL_OP_BIT];
        end
        ADDR_RX_GAIN: begin
          nxt_st.rx_gain = (pwdata[31:0] > 32'(RX_GAIN_MAX)) ? RX_GAIN_MAX
                                                            : pwdata[3:0];
        end
        ADDR_TX_LEVEL: begin
          nxt_st.tx_set = pwdata[4:0];
          nxt_st.tx_lvl = pwdata[4:0];
        end
        ADDR_ZC_DELAY: begin
          nxt_st.zc_delay = pwdata[15:0];
        end
        default: begin
          nxt_st.zc_delay = st_ff.zc_delay;
        end
      endcase
    end
    // Attenuation follows the level it will be applied with
    nxt_st.atten = $signed({1'b0, nxt_st.tx_lvl}) - ATTEN_OFFSET;
    // Read data captured in the setup phase
    if (rd_setup) begin
      nxt_st.rdata = '0;
      case (paddr)
        ADDR_CTRL: begin
          nxt_st.rdata[CTRL_AGC_BIT]    = st_ff.agc_en;
          nxt_st.rdata[CTRL_ZC_DIG_BIT] = st_ff.zc_dig;
          nxt_st.rdata[CTRL_OP_BIT]     = st_ff.op_mode;
        end
        ADDR_RX_GAIN: nxt_st.rdata[3:0] = st_ff.rx_gain;
        ADDR_TX_LEVEL: begin
          nxt_st.rdata[4:0] = st_ff.tx_set;
          nxt_st.rdata[TX_APPLIED_LSB +: 5] = st_ff.tx_lvl;
        end
        ADDR_ZC_DELAY: nxt_st.rdata[15:0] = st_ff.zc_delay;
        ADDR_STATUS: begin
          nxt_st.rdata[STAT_ZONE_LSB +: 3] = st_ff.zone;
          nxt_st.rdata[STAT_AMP_BIT]       = st_ff.amp_en;
          nxt_st.rdata[STAT_LOCK_BIT]      = zc_locked;
          nxt_st.rdata[STAT_SHUT_BIT]      = !st_ff.amp_en;
          nxt_st.rdata[STAT_FOLD_BIT]      = st_ff.fold_act;
        end
        ADDR_ZC_PERIOD: nxt_st.rdata[ZC_CNT_W-1:0] = zc_period;
        default: nxt_st.rdata = '0;
      endcase
    end
  end

  // ****************************************************
  // State register, frozen while clock enable is low
  // ****************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff         <= '0;
      st_ff.agc_en  <= 1'b1;
      st_ff.rx_gain <= RX_GAIN_UNITY;
      st_ff.tx_set  <= TX_LEVEL_MAX;
      st_ff.tx_lvl  <= TX_LEVEL_MAX;
      st_ff.amp_en  <= 1'b1;
      st_ff.zone    <= ZONE_ONE;
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  assign rx_gain_code        = st_ff.rx_gain;
  assign tx_level            = st_ff.tx_lvl;
  assign tx_atten_db         = st_ff.atten;
  assign amp_enable          = st_ff.amp_en;
  assign temp_zone           = st_ff.zone;
  assign protocol_core_clock = st_ff.proto_clk;

  // ****************************************************
  // Assertions
  // ****************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  gain_range_a: assert property (rx_gain_code <= RX_GAIN_MAX)
    else $error("receive gain code above eight");
  agc_down_a: assert property (
    clk_en && st_ff.agc_en && agc_tick && s_over && !wr_en
    && rx_gain_code != RX_GAIN_MIN |=> rx_gain_code == $past(rx_gain_code) - 1)
    else $error("gain loop did not step down on overload");
  agc_floor_a: assert property (
    clk_en && rx_gain_code == RX_GAIN_MIN && s_over && !wr_en
    |=> rx_gain_code == RX_GAIN_MIN)
    else $error("gain code wrapped below zero");
  atten_map_a: assert property (tx_atten_db == $signed({1'b0, tx_level}) - 31)
    else $error("attenuation does not match level");
  fold_step_a: assert property (
    clk_en && fold_tick && s_cur && tx_level != 0 && !wr_en
    |=> tx_level == $past(tx_level) - 1)
    else $error("foldback did not lower level by one");
  fold_floor_a: assert property (
    clk_en && tx_level == 0 && !wr_en |=> tx_level == 0)
    else $error("foldback wrapped below zero");
  amp_off_a: assert property (clk_en && s_t4 |=> !amp_enable)
    else $error("amplifier not shut down above threshold four");
  amp_hold_a: assert property (
    clk_en && !amp_enable && s_t3 |=> !amp_enable)
    else $error("amplifier re-enabled above threshold three");
  zone_map_a: assert property (
    clk_en && s_t1 && !s_t2 && !s_t3 |=> temp_zone == ZONE_TWO)
    else $error("zone two not reported");
  proto_div_a: assert property (
    clk_en |=> protocol_core_clock != $past(protocol_core_clock))
    else $error("protocol clock not half rate");

  shutdown_c: cover property (amp_enable ##1 !amp_enable);
  foldback_c: cover property (fold_tick && s_cur ##1 tx_level != st_ff.tx_set);
  agc_move_c: cover property (agc_tick && s_under && st_ff.agc_en);
  zc_lock_c:  cover property (!zc_locked ##1 zc_locked);

endmodule
`default_nettype wire

// File: sim/agtz_line_model.sv
// Line-side model: converter range flags, current sense, sensors, mains
`timescale 1ns/1ns
`default_nettype none
module agtz_line_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        over_cmd,
  input  wire logic        under_cmd,
  input  wire logic        cur_cmd,
  input  wire logic [2:0]  temp_lvl,
  input  wire logic [15:0] zc_half,
  input  wire logic        zc_dig,
  output logic             adc_over_range,
  output logic             adc_under_range,
  output logic             current_sense_pin,
  output logic             temp_threshold_one,
  output logic             temp_threshold_two,
  output logic             temp_threshold_three,
  output logic             temp_threshold_four,
  output logic             zero_cross_analog_input,
  output logic             zero_cross_digital_input
);
  logic [15:0] cnt_ff;
  logic        wave_ff;
  // ****************************************************
  // Mains square wave, equal halves, pclk-exact period
  // ****************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff  <= 16'h0;
      wave_ff <= 1'b0;
    end else if (zc_half != 16'h0) begin
      cnt_ff <= (cnt_ff + 16'h1 >= zc_half) ? 16'h0 : cnt_ff + 16'h1;
      if (cnt_ff + 16'h1 >= zc_half) begin
        wave_ff <= ~wave_ff;
      end
    end
  end
  // Idle pin held low so only the chosen source carries edges
  assign zero_cross_digital_input = zc_dig & wave_ff;
  assign zero_cross_analog_input  = ~zc_dig & wave_ff;
  // Sensor comparators: higher level sets every lower threshold too
  assign temp_threshold_one   = temp_lvl >= 3'h1;
  assign temp_threshold_two   = temp_lvl >= 3'h2;
  assign temp_threshold_three = temp_lvl >= 3'h3;
  assign temp_threshold_four  = temp_lvl >= 3'h4;
  assign adc_over_range       = over_cmd;
  assign adc_under_range      = under_cmd;
  assign current_sense_pin    = cur_cmd;
endmodule
`default_nettype wire

// File: sim/testbench.sv
// Self-checking bench for the front-end control block
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module testbench
  import agtz_pkg::*;
;
  localparam int AC = 8;
  localparam int FC = 4;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ce = 1;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, over = 0, under = 0, cur = 0, zdig = 0;
  logic adc_o, adc_u, cs, t1, t2, t3, t4, zca, zcd, amp, zref, zlk, pcc;
  logic [2:0] tlvl = 3'h0, temp_zone;
  logic [15:0] zhalf = 16'h0;
  logic [3:0] rx_gain_code;
  logic [4:0] tx_level;
  logic signed [5:0] tx_atten_db;
  int num_errors = 0, cmp_count = 0, n, g0;
  logic [2:0] zt [8] = '{3'h2, 3'h3, 3'h4, 3'h4, 3'h4, 3'h3, 3'h2, 3'h1};
  logic       at [8] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
  always #10 pclk = ~pclk;
  agtz_afe_ctrl #(.AGC_CYC(AC), .FOLD_CYC(FC)) u_agtz_afe_ctrl (
    .pclk(pclk), .presetn(presetn), .clk_en(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .adc_over_range(adc_o), .adc_under_range(adc_u),
    .current_sense_pin(cs), .temp_threshold_one(t1),
    .temp_threshold_two(t2), .temp_threshold_three(t3),
    .temp_threshold_four(t4), .zero_cross_analog_input(zca),
    .zero_cross_digital_input(zcd), .rx_gain_code(rx_gain_code),
    .tx_level(tx_level), .tx_atten_db(tx_atten_db), .amp_enable(amp),
    .temp_zone(temp_zone), .zc_ref_pulse(zref), .zc_locked(zlk),
    .protocol_core_clock(pcc));
  agtz_line_model u_agtz_line_model (
    .pclk(pclk), .presetn(presetn), .over_cmd(over), .under_cmd(under),
    .cur_cmd(cur), .temp_lvl(tlvl), .zc_half(zhalf), .zc_dig(zdig),
    .adc_over_range(adc_o), .adc_under_range(adc_u),
    .current_sense_pin(cs), .temp_threshold_one(t1),
    .temp_threshold_two(t2), .temp_threshold_three(t3),
    .temp_threshold_four(t4), .zero_cross_analog_input(zca),
    .zero_cross_digital_input(zcd));
  // ****************************************************
  // Verdict and bus tasks
  // ****************************************************
  task automatic complete_run();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // One APB transfer; the request holds until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel    <= 1;
    penable <= 0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    err = pslverr;
    psel    <= 0;
    penable <= 0;
    if (pready !== 1'b1) begin
      num_errors++;
      complete_run();
    end
  endtask
  // Checks made at the edge see what the previous edge launched
  task automatic wt(input int c);
    repeat (c) @(posedge pclk);
  endtask
  // Cycles from a mains rising edge on the pin to the next reference pulse
  task automatic gap(output int g);
    int k;
    k = 0;
    while (zcd !== 1'b0 && k < 9000) begin
      @(posedge pclk);
      k++;
    end
    while (zcd !== 1'b1 && k < 9000) begin
      @(posedge pclk);
      k++;
    end
    g = 0;
    while (zref !== 1'b1 && g < 9000) begin
      @(posedge pclk);
      g++;
    end
  endtask
  initial begin
    wt(12);
    presetn <= 1;
    wt(1);
    `CHK(rx_gain_code, RX_GAIN_UNITY)
    `CHK(tx_atten_db, 6'sh0)
    apb(0, ADDR_CTRL, 0);
    `CHK(rd, 32'h1)
    apb(0, 8'h18, 0);
    `CHK({err, rd}, {1'b1, 32'h0})
    // Protocol clock toggles each enabled edge and freezes with enable low
    rd[0] = pcc;
    wt(1);
    `CHK(pcc, ~rd[0])
    ce <= 0;
    wt(1);
    rd[0] = pcc;
    wt(3);
    `CHK(pcc, rd[0])
    `CHK(pready, 1'b0)
    ce <= 1;
    for (int i = 0; i < 32; i += 15) begin
      apb(1, ADDR_TX_LEVEL, i);
      wt(2);
      `CHK(tx_atten_db, 6'(i - 31))
      apb(0, ADDR_TX_LEVEL, 0);
      `CHK(rd, 32'(i) | 32'(i) << 8)
    end
    // Gain loop off while poking the code, then let it run to both ends
    apb(1, ADDR_CTRL, 0);
    apb(1, ADDR_RX_GAIN, 12);
    apb(0, ADDR_RX_GAIN, 0);
    `CHK(rd, 32'h8)
    over <= 1;
    apb(1, ADDR_CTRL, 1);
    wt(12 * AC);
    `CHK(rx_gain_code, RX_GAIN_MIN)
    over  <= 0;
    under <= 1;
    wt(12 * AC);
    `CHK(rx_gain_code, RX_GAIN_MAX)
    under <= 0;
    cur   <= 1;
    apb(1, ADDR_TX_LEVEL, 3);
    wt(10 * FC);
    apb(0, ADDR_TX_LEVEL, 0);
    `CHK(rd, 32'h3)
    cur <= 0;
    apb(1, ADDR_TX_LEVEL, 20);
    wt(10 * FC);
    `CHK(tx_level, 5'd20)
    // Thermal walk up to shutdown and back down through the hysteresis
    for (int i = 0; i < 8; i++) begin
      tlvl <= (i < 4) ? 3'(i + 1) : 3'(7 - i);
      wt(6);
      `CHK(temp_zone, zt[i])
      `CHK(amp, at[i])
      if (i == 3) begin
        apb(0, ADDR_STATUS, 0);
        `CHK(rd, 32'h24)
      end
    end
    // Mains on the digital pin; analog selected first must not lock
    zdig  <= 1;
    zhalf <= 16'd2000;
    apb(1, ADDR_CTRL, 32'h4);
    wt(12000);
    `CHK(zlk, 1'b0)
    apb(1, ADDR_ZC_DELAY, 32'h100);
    apb(0, ADDR_ZC_DELAY, 0);
    `CHK(rd, 32'h100)
    apb(1, ADDR_CTRL, 32'h6);
    n = 0;
    while (zlk !== 1'b1 && n < 20000) begin
      wt(1);
      n++;
    end
    `CHK(zlk, 1'b1)
    apb(0, ADDR_ZC_PERIOD, 0);
    `CHK(rd, 32'd4000)
    n = 0;
    repeat (8000) begin
      @(posedge pclk);
      n += (zref === 1'b1);
    end
    `CHK(n, 2)
    // Raising the delay by 256 cycles moves the pulse by exactly that much
    gap(g0);
    apb(1, ADDR_ZC_DELAY, 32'h200);
    gap(n);
    `CHK(n - g0, 256)
    complete_run();
  end
endmodule
`default_nettype wire
